// file: include/tsc_consts.svh
// Constants for the teach-in and system-condition telegram codec
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH
`define TSC_RORG_TEACH 8'hD4
`define TSC_RORG_SIGNAL 8'hD0
`define TSC_CTRL_USUAL 8'h40
`define TSC_CHAN_ALL 8'hFF
`define TSC_DIR_BIT 7
`define TSC_RESP_BIT 6
`define TSC_KIND_HI 5
`define TSC_KIND_LO 4
`define TSC_ROLE_HI 3
`define TSC_ROLE_LO 0
`define TSC_KIND_ADD 2'h0
`define TSC_KIND_DEL 2'h1
`define TSC_KIND_EITHER 2'h2
`define TSC_KIND_RSVD 2'h3
`define TSC_ROLE_REQ 4'h0
`define TSC_ROLE_RSP 4'h1
`define TSC_MID_ENERGY 8'h06
`define TSC_MID_HARVEST 8'h0D
`define TSC_MID_RADIO_OFF 8'h0E
`define TSC_MID_RADIO_ON 8'h0F
`define TSC_MID_BACKUP 8'h10
`define TSC_PCT_MAX 8'h64
`define TSC_HARVEST_MAX 8'h04
`define TSC_V1_BCAST_MAX 8'h0E
`define TSC_V1_ADDR_MAX 8'h09
`define TSC_V2_SMALL_MAX 8'h17
`define TSC_V2_LARGE_MAX 8'h2C
`define TSC_TEACH_LAST 4'h7
`define TSC_TEACH_LEN 4'h8
`define TSC_SIG_LEN_BARE 4'h2
`define TSC_SIG_LEN_DATA 4'h3
`define TSC_OFF_CMD 8'h00
`define TSC_OFF_TX_TEACH 8'h04
`define TSC_OFF_TX_PROF 8'h08
`define TSC_OFF_TX_SIG 8'h0C
`define TSC_OFF_STATUS 8'h10
`define TSC_OFF_RX_TEACH 8'h14
`define TSC_OFF_RX_PROF 8'h18
`define TSC_OFF_RX_SIG 8'h1C
`define TSC_OFF_RX_DEC 8'h20
`define TSC_OFF_SIZE_CFG 8'h24
`define TSC_OFF_SIZE_STAT 8'h28
`define TSC_FLG_TX_ERR 0
`define TSC_FLG_TEACH_OK 1
`define TSC_FLG_TEACH_BAD 2
`define TSC_FLG_SIG_OK 3
`define TSC_FLG_SIG_BAD 4
`define TSC_NFLG 5
`endif

// file: include/tsc_pkg.sv
// Types for the telegram codec
package tsc_pkg;
  typedef enum logic [1:0] {TSC_IDLE = 2'b01, TSC_SEND = 2'b10} tsc_tx_state_t;
endpackage : tsc_pkg

// file: verilog/tsc_codec.sv
// Teach-in and system-condition telegram codec with AHB-Lite registers
//
// Notes on behaviour
// - Teach-in frames start with type code 0xD4
// - Control byte: direction, response, kind, role
// - Direction 0 one-way, 1 two-way
// - Response 0 reply expected, 1 none
// - Kind 00 add, 01 delete, 10 either
// - Role 0000 request, 0001 response only
// - Control 0x40 is one-way add, no reply
// - Channel 0xFF means all domains
// - Maker code sent low byte first
// - Last three bytes give equipment profile
// - Condition frame: 0xD0, code, data
// - Energy and backup percentages 0 to 100
// - Harvester delivery enumeration 0 to 4
// - Radio off/on codes carry no data
// - Protocol one: 14 broadcast, 9 addressed
// - Protocol two: 23 or 44 bytes
// - Security bytes reduce allowed payload
// - Oversize payload must be chained
// - Plain or secure chaining by message type
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`include "tsc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tsc_codec (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_last,
  input wire logic i_tx_ready
);
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic [31:0] tx_teach_q;
  logic [23:0] tx_prof_q;
  logic [15:0] tx_sig_q;
  logic [31:0] size_cfg_q;
  logic [`TSC_NFLG-1:0] flg_q;
  logic [`TSC_NFLG-1:0] flg_set;
  logic [31:0] rx_teach_q;
  logic [23:0] rx_prof_q;
  logic [15:0] rx_sig_q;
  tsc_pkg::tsc_tx_state_t st_q;
  tsc_pkg::tsc_tx_state_t st_d;
  logic [63:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic [3:0] tx_pos_q;
  logic tx_teach_q_f;
  logic [3:0] rx_pos_q;
  logic [7:0] rx_type_q;
  logic [7:0] stg_q [1:6];

  // Bus decode; slave never stalls and always answers OKAY
  wire acc = i_hsel && i_htrans[1] && i_hready;
  wire rd_acc = acc && !i_hwrite;
  wire [7:0] ra = i_haddr[7:0];
  wire wr_cmd = wr_pend_q && (wr_addr_q == `TSC_OFF_CMD);
  wire wr_tteach = wr_pend_q && (wr_addr_q == `TSC_OFF_TX_TEACH);
  wire wr_tprof = wr_pend_q && (wr_addr_q == `TSC_OFF_TX_PROF);
  wire wr_tsig = wr_pend_q && (wr_addr_q == `TSC_OFF_TX_SIG);
  wire wr_stat = wr_pend_q && (wr_addr_q == `TSC_OFF_STATUS);
  wire wr_size = wr_pend_q && (wr_addr_q == `TSC_OFF_SIZE_CFG);

  // Received control byte split
  wire [7:0] rx_ctrl = rx_teach_q[7:0];
  wire rx_two_way = rx_ctrl[`TSC_DIR_BIT];
  wire rx_no_reply = rx_ctrl[`TSC_RESP_BIT];
  wire [1:0] rx_kind = rx_ctrl[`TSC_KIND_HI:`TSC_KIND_LO];
  wire [3:0] rx_role = rx_ctrl[`TSC_ROLE_HI:`TSC_ROLE_LO];
  wire rx_usual = !rx_two_way && rx_no_reply && (rx_kind == `TSC_KIND_ADD) && (rx_role == `TSC_ROLE_REQ);
  wire rx_all_dom = (rx_teach_q[15:8] == `TSC_CHAN_ALL);
  wire [31:0] rx_dec = {22'h0, rx_all_dom, rx_usual, rx_role, rx_kind, rx_no_reply, rx_two_way};

  // Single-frame payload limit and chaining decision
  wire [7:0] pay_len = size_cfg_q[7:0];
  wire cfg_v2 = size_cfg_q[16];
  wire cfg_addr = size_cfg_q[17];
  wire cfg_large = size_cfg_q[18];
  wire cfg_secure = size_cfg_q[19];
  wire [7:0] sec_bytes = cfg_secure ? {4'h0, size_cfg_q[27:24]} : 8'h00;
  wire [7:0] v1_max = cfg_addr ? `TSC_V1_ADDR_MAX : `TSC_V1_BCAST_MAX;
  wire [7:0] v2_max = cfg_large ? `TSC_V2_LARGE_MAX : `TSC_V2_SMALL_MAX;
  wire [7:0] base_max = cfg_v2 ? v2_max : v1_max;
  wire [7:0] avail = (base_max > sec_bytes) ? (base_max - sec_bytes) : 8'h00;
  wire chain_need = (pay_len > avail);
  wire chain_secure = chain_need && cfg_secure;
  wire chain_plain = chain_need && !cfg_secure;
  wire [31:0] size_stat = {21'h0, chain_plain, chain_secure, chain_need, avail};

  wire [31:0] rd_mux =
    (ra == `TSC_OFF_TX_TEACH) ? tx_teach_q :
    (ra == `TSC_OFF_TX_PROF) ? {8'h0, tx_prof_q} :
    (ra == `TSC_OFF_TX_SIG) ? {16'h0, tx_sig_q} :
    (ra == `TSC_OFF_STATUS) ? {26'h0, flg_q, st_q == tsc_pkg::TSC_SEND} :
    (ra == `TSC_OFF_RX_TEACH) ? rx_teach_q :
    (ra == `TSC_OFF_RX_PROF) ? {8'h0, rx_prof_q} :
    (ra == `TSC_OFF_RX_SIG) ? {16'h0, rx_sig_q} :
    (ra == `TSC_OFF_RX_DEC) ? rx_dec :
    (ra == `TSC_OFF_SIZE_CFG) ? size_cfg_q :
    (ra == `TSC_OFF_SIZE_STAT) ? size_stat : 32'h0;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0;
    end
    else
    begin
      wr_pend_q <= acc && i_hwrite;
      wr_addr_q <= ra;
      rdata_q <= rd_acc ? rd_mux : 32'h0;
    end
  end

  assign o_hrdata = rdata_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // Build side: reserved kind or role in the staged control byte refuses the build
  wire [7:0] tx_ctrl = tx_teach_q[7:0];
  wire tx_rsvd = (tx_ctrl[`TSC_KIND_HI:`TSC_KIND_LO] == `TSC_KIND_RSVD) ||
                 (tx_ctrl[`TSC_ROLE_HI:`TSC_ROLE_LO] > `TSC_ROLE_RSP);
  wire idle = (st_q == tsc_pkg::TSC_IDLE);
  wire go_teach = wr_cmd && i_hwdata[0] && idle;
  wire go_sig = wr_cmd && i_hwdata[1] && !i_hwdata[0] && idle;
  wire load_teach = go_teach && !tx_rsvd;
  wire sig_bare = (tx_sig_q[7:0] == `TSC_MID_RADIO_OFF) || (tx_sig_q[7:0] == `TSC_MID_RADIO_ON);
  // Byte order on the wire, lowest first: type, control, channel, maker lo, maker hi, variant, function, type
  wire [63:0] teach_img = {tx_prof_q[7:0], tx_prof_q[15:8], tx_prof_q[23:16],
                           tx_teach_q[31:24], tx_teach_q[23:16], tx_teach_q[15:8], tx_ctrl, `TSC_RORG_TEACH};
  wire [63:0] sig_img = {40'h0, tx_sig_q[15:8], tx_sig_q[7:0], `TSC_RORG_SIGNAL};
  wire tx_fire = o_tx_valid && i_tx_ready;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      tsc_pkg::TSC_IDLE:
        if (load_teach || go_sig)
          st_d = tsc_pkg::TSC_SEND;
      tsc_pkg::TSC_SEND:
        if (tx_fire && (tx_cnt_q == 4'h1))
          st_d = tsc_pkg::TSC_IDLE;
      default:
        st_d = tsc_pkg::TSC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      st_q <= tsc_pkg::TSC_IDLE;
      tx_sh_q <= 64'h0;
      tx_cnt_q <= 4'h0;
      tx_pos_q <= 4'h0;
      tx_teach_q_f <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (load_teach)
      begin
        tx_sh_q <= teach_img;
        tx_cnt_q <= `TSC_TEACH_LEN;
        tx_pos_q <= 4'h0;
        tx_teach_q_f <= 1'b1;
      end
      else if (go_sig)
      begin
        tx_sh_q <= sig_img;
        tx_cnt_q <= sig_bare ? `TSC_SIG_LEN_BARE : `TSC_SIG_LEN_DATA;
        tx_pos_q <= 4'h0;
        tx_teach_q_f <= 1'b0;
      end
      else if (tx_fire)
      begin
        tx_sh_q <= {8'h00, tx_sh_q[63:8]};
        tx_cnt_q <= tx_cnt_q - 4'h1;
        tx_pos_q <= tx_pos_q + 4'h1;
      end
    end
  end

  assign o_tx_valid = (st_q == tsc_pkg::TSC_SEND);
  assign o_tx_data = tx_sh_q[7:0];
  assign o_tx_last = o_tx_valid && (tx_cnt_q == 4'h1);

  // Receive side; frames longer than 16 bytes pin the position at 15
  wire rx_first = (rx_pos_q == 4'h0);
  wire [7:0] rx_type = rx_first ? i_rx_data : rx_type_q;
  wire rx_end = i_rx_valid && i_rx_last;

  genvar gi;
  generate
    for (gi = 1; gi <= 6; gi = gi + 1)
    begin : g_stage
      always_ff @(posedge i_clk_sys)
      begin
        if (i_sys_rst)
          stg_q[gi] <= 8'h00;
        else if (i_rx_valid && (rx_pos_q == 4'(gi)))
          stg_q[gi] <= i_rx_data;
      end
    end
  endgenerate

  // Eighth teach byte is used live, so it needs no stage
  wire [7:0] r_ctrl = stg_q[1];
  wire r_rsvd = (r_ctrl[`TSC_KIND_HI:`TSC_KIND_LO] == `TSC_KIND_RSVD) ||
                (r_ctrl[`TSC_ROLE_HI:`TSC_ROLE_LO] > `TSC_ROLE_RSP);
  wire teach_end = rx_end && (rx_type == `TSC_RORG_TEACH);
  wire teach_ok = teach_end && (rx_pos_q == `TSC_TEACH_LAST) && !r_rsvd;
  wire teach_bad = teach_end && !teach_ok;
  wire [7:0] r_mid = (rx_pos_q == 4'h1) ? i_rx_data : stg_q[1];
  wire r_bare = (r_mid == `TSC_MID_RADIO_OFF) || (r_mid == `TSC_MID_RADIO_ON);
  wire r_pct = (r_mid == `TSC_MID_ENERGY) || (r_mid == `TSC_MID_BACKUP);
  wire r_range_bad = (r_pct && (i_rx_data > `TSC_PCT_MAX)) ||
                     ((r_mid == `TSC_MID_HARVEST) && (i_rx_data > `TSC_HARVEST_MAX));
  wire sig_end = rx_end && (rx_type == `TSC_RORG_SIGNAL);
  wire sig_len_ok = r_bare ? (rx_pos_q == 4'h1) : (rx_pos_q == 4'h2);
  wire sig_ok = sig_end && sig_len_ok && (r_bare || !r_range_bad);
  wire sig_bad = sig_end && !sig_ok;

  assign flg_set = {sig_bad, sig_ok, teach_bad, teach_ok, go_teach && tx_rsvd};

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      rx_pos_q <= 4'h0;
      rx_type_q <= 8'h00;
      flg_q <= '0;
      rx_teach_q <= 32'h0;
      rx_prof_q <= 24'h0;
      rx_sig_q <= 16'h0;
    end
    else
    begin
      if (rx_end)
        rx_pos_q <= 4'h0;
      else if (i_rx_valid && (rx_pos_q != 4'hF))
        rx_pos_q <= rx_pos_q + 4'h1;
      if (i_rx_valid && rx_first)
        rx_type_q <= i_rx_data;
      // New event wins over a same-cycle clear
      flg_q <= (flg_q & ~(wr_stat ? i_hwdata[`TSC_NFLG:1] : {`TSC_NFLG{1'b0}})) | flg_set;
      if (teach_ok)
      begin
        rx_teach_q <= {stg_q[4], stg_q[3], stg_q[2], stg_q[1]};
        rx_prof_q <= {stg_q[5], stg_q[6], i_rx_data};
      end
      if (sig_ok)
        rx_sig_q <= {r_bare ? 8'h00 : i_rx_data, r_mid};
    end
  end

  // Configuration registers written in the data phase
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      tx_teach_q <= {16'h0, `TSC_CHAN_ALL, `TSC_CTRL_USUAL};
      tx_prof_q <= 24'h0;
      tx_sig_q <= 16'h0;
      size_cfg_q <= 32'h0;
    end
    else
    begin
      if (wr_tteach && idle)
        tx_teach_q <= i_hwdata;
      if (wr_tprof && idle)
        tx_prof_q <= i_hwdata[23:0];
      if (wr_tsig && idle)
        tx_sig_q <= i_hwdata[15:0];
      if (wr_size)
        size_cfg_q <= {4'h0, i_hwdata[27:24], 4'h0, i_hwdata[19:16], 8'h0, i_hwdata[7:0]};
    end
  end

  sequence s_teach_start;
    $rose(o_tx_valid) && tx_teach_q_f;
  endsequence
  property p_teach_type;
    @(posedge i_clk_sys) disable iff (i_sys_rst) s_teach_start |-> o_tx_data == `TSC_RORG_TEACH;
  endproperty
  a_teach_type: assert property (p_teach_type) else $error("teach frame without type code");
  property p_no_rsvd_tx;
    @(posedge i_clk_sys) disable iff (i_sys_rst) go_teach && tx_rsvd |=> !o_tx_valid && flg_q[`TSC_FLG_TX_ERR];
  endproperty
  a_no_rsvd_tx: assert property (p_no_rsvd_tx) else $error("reserved control byte was sent");
  property p_maker_order;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_tx_valid && tx_teach_q_f && tx_pos_q == 4'h3 |-> o_tx_data == tx_teach_q[23:16];
  endproperty
  a_maker_order: assert property (p_maker_order) else $error("maker code not low byte first");
  property p_sig_bare_len;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_tx_last && !tx_teach_q_f && sig_bare |-> tx_pos_q == 4'h1;
  endproperty
  a_sig_bare_len: assert property (p_sig_bare_len) else $error("radio on/off carried data");
  property p_rx_malformed;
    @(posedge i_clk_sys) disable iff (i_sys_rst) teach_end && r_rsvd |=> flg_q[`TSC_FLG_TEACH_BAD] && $stable(rx_teach_q);
  endproperty
  a_rx_malformed: assert property (p_rx_malformed) else $error("reserved frame accepted");
  property p_usual;
    @(posedge i_clk_sys) disable iff (i_sys_rst) rx_ctrl == `TSC_CTRL_USUAL |-> rx_usual && !rx_two_way;
  endproperty
  a_usual: assert property (p_usual) else $error("usual control byte misdecoded");
  property p_pct_range;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      sig_end && r_pct && rx_pos_q == 4'h2 && i_rx_data > `TSC_PCT_MAX |=> flg_q[`TSC_FLG_SIG_BAD];
  endproperty
  a_pct_range: assert property (p_pct_range) else $error("percentage over range accepted");
  property p_v1_limit;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      !cfg_v2 && !cfg_secure && pay_len > (cfg_addr ? 8'h09 : 8'h0E) |-> chain_plain;
  endproperty
  a_v1_limit: assert property (p_v1_limit) else $error("protocol one limit missed");
  property p_secure_chain;
    @(posedge i_clk_sys) disable iff (i_sys_rst) chain_need |-> (chain_secure == cfg_secure) && (chain_plain != cfg_secure);
  endproperty
  a_secure_chain: assert property (p_secure_chain) else $error("wrong chaining type");
  sequence s_sig_start;
    $rose(o_tx_valid) && !tx_teach_q_f;
  endsequence
  property p_sig_type;
    @(posedge i_clk_sys) disable iff (i_sys_rst) s_sig_start |-> o_tx_data == `TSC_RORG_SIGNAL;
  endproperty
  a_sig_type: assert property (p_sig_type) else $error("condition frame without type code");
  // Stalled byte must hold until the sink takes it
  property p_tx_hold;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte changed during stall");
  property p_teach_tail;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_tx_last && tx_teach_q_f |-> tx_pos_q == `TSC_TEACH_LAST && o_tx_data == tx_prof_q[7:0];
  endproperty
  a_teach_tail: assert property (p_teach_tail) else $error("profile type not last teach byte");
  property p_rx_profile;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      teach_ok |=> rx_prof_q == {stg_q[5], stg_q[6], $past(i_rx_data)};
  endproperty
  a_rx_profile: assert property (p_rx_profile) else $error("received profile misplaced");
  property p_harvest_range;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      sig_end && (r_mid == `TSC_MID_HARVEST) && rx_pos_q == 4'h2 && i_rx_data > `TSC_HARVEST_MAX |=> flg_q[`TSC_FLG_SIG_BAD];
  endproperty
  a_harvest_range: assert property (p_harvest_range) else $error("harvester value over range accepted");
  property p_v2_limit;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      cfg_v2 && !cfg_secure && pay_len > (cfg_large ? `TSC_V2_LARGE_MAX : `TSC_V2_SMALL_MAX) |-> chain_plain;
  endproperty
  a_v2_limit: assert property (p_v2_limit) else $error("protocol two limit missed");
endmodule : tsc_codec
`default_nettype wire

// file: sim/tsc_radio_peer.sv
// Radio-side peer: sink for built frames, source for received frames
`timescale 1ns/1ps
`default_nettype none
module tsc_radio_peer (
  input wire logic i_clk_sys,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_last,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_last
);
  logic [7:0] got_q[$];
  int done = 0;
  logic [1:0] ph_q = 2'h0;
  initial
  begin
    o_tx_ready = 1'b1;
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_last = 1'b0;
  end
  // Refuse one edge in four so some bytes must hold through a stall
  always @(posedge i_clk_sys)
  begin
    ph_q <= ph_q + 2'h1;
    o_tx_ready <= (ph_q != 2'h1);
    if (i_tx_valid && o_tx_ready)
    begin
      got_q.push_back(i_tx_data);
      if (i_tx_last)
        done <= done + 1;
    end
  end
  // Bytes go out back to back; the line is scrambled once the frame ends
  task automatic send(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++)
    begin
      @(posedge i_clk_sys);
      o_rx_valid <= 1'b1;
      o_rx_data <= b[i];
      o_rx_last <= (i == b.size() - 1);
    end
    @(posedge i_clk_sys);
    o_rx_valid <= 1'b0;
    o_rx_last <= 1'b0;
    o_rx_data <= ~b[b.size() - 1];
  endtask : send
endmodule : tsc_radio_peer
`default_nettype wire

// file: sim/teach_in_signal_telegram_codec_tb.sv
// Self-checking bench for the telegram codec
`timescale 1ns/1ps
`default_nettype none
module teach_in_signal_telegram_codec_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp, tx_valid, tx_last, tx_ready, rx_valid, rx_last;
  logic [7:0] tx_data, rx_data;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  tsc_codec dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_last(rx_last),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last), .i_tx_ready(tx_ready));
  tsc_radio_peer peer_u (.i_clk_sys(clk), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_last(tx_last),
    .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_last(rx_last));
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  // Whole run needs a few hundred cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0, "bus response");
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp, what);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic tx_frame(input logic [31:0] cmd, input logic [7:0] e[$]);
    int n;
    n = peer_u.done;
    peer_u.got_q.delete();
    wr(8'h00, cmd);
    while (peer_u.done == n)
      @(posedge clk);
    @(posedge clk);
    chk(32'(peer_u.got_q.size()), 32'(e.size()), "tx length");
    for (int i = 0; i < e.size(); i++)
      chk({24'h0, peer_u.got_q[i]}, {24'h0, e[i]}, "tx byte");
  endtask : tx_frame
  task automatic rx_frame(input logic [7:0] b[$], input logic [31:0] exp);
    wr(8'h10, 32'h3E);
    peer_u.send(b);
    rd(8'h10, exp, "rx flags");
  endtask : rx_frame
  task automatic t_regs();
    rd(8'h04, 32'h0000FF40, "teach reset");
    rd(8'h3C, 32'h0, "unmapped");
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0, "unmapped after write");
    $display("test regs done");
  endtask : t_regs
  task automatic t_tx_teach();
    logic [7:0] c[3] = '{8'h80, 8'h11, 8'hE0};
    wr(8'h04, 32'h05A3FF40);
    wr(8'h08, 32'h000201D2);
    tx_frame(32'h1, '{8'hD4, 8'h40, 8'hFF, 8'hA3, 8'h05, 8'h02, 8'h01, 8'hD2});
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h04, {16'h05A3, 8'h07, c[i]});
      tx_frame(32'h3, '{8'hD4, c[i], 8'h07, 8'hA3, 8'h05, 8'h02, 8'h01, 8'hD2});
    end
    c = '{8'h30, 8'h42, 8'h4F};
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h10, 32'h3E);
      peer_u.got_q.delete();
      wr(8'h04, {16'h05A3, 8'hFF, c[i]});
      wr(8'h00, 32'h1);
      repeat (12) @(posedge clk);
      chk(32'(peer_u.got_q.size()), 32'h0, "reserved sent");
      rd(8'h10, 32'h2, "reserved flag");
    end
    $display("test tx teach done");
  endtask : t_tx_teach
  task automatic t_tx_sig();
    wr(8'h0C, 32'h00003206);
    tx_frame(32'h2, '{8'hD0, 8'h06, 8'h32});
    wr(8'h0C, 32'h0000550E);
    tx_frame(32'h2, '{8'hD0, 8'h0E});
    wr(8'h0C, 32'h0000550F);
    tx_frame(32'h2, '{8'hD0, 8'h0F});
    $display("test tx condition done");
  endtask : t_tx_sig
  task automatic t_rx_teach();
    rx_frame('{8'hD4, 8'h81, 8'h05, 8'hA3, 8'h05, 8'h02, 8'h01, 8'hD2}, 32'h04);
    rd(8'h14, 32'h05A30581, "rx teach");
    rd(8'h18, 32'h000201D2, "rx profile");
    rd(8'h20, 32'h00000011, "rx decode two way");
    rx_frame('{8'hD4, 8'h40, 8'hFF, 8'h11, 8'h22, 8'h03, 8'h04, 8'hA5}, 32'h04);
    rd(8'h20, 32'h00000302, "rx decode usual");
    rx_frame('{8'hD4, 8'h70, 8'hFF, 8'h11, 8'h22, 8'h03, 8'h04, 8'hA5}, 32'h08);
    rx_frame('{8'hD4, 8'h42, 8'hFF, 8'h11, 8'h22, 8'h03, 8'h04, 8'hA5}, 32'h08);
    rx_frame('{8'hD4, 8'h40, 8'hFF, 8'h11, 8'h22, 8'h03, 8'h04}, 32'h08);
    rd(8'h14, 32'h2211FF40, "rx teach kept");
    $display("test rx teach done");
  endtask : t_rx_teach
  task automatic t_rx_sig();
    rx_frame('{8'hD0, 8'h06, 8'h64}, 32'h10);
    rd(8'h1C, 32'h00006406, "rx condition");
    rx_frame('{8'hD0, 8'h06, 8'h65}, 32'h20);
    rx_frame('{8'hD0, 8'h10, 8'h00}, 32'h10);
    rx_frame('{8'hD0, 8'h10, 8'h65}, 32'h20);
    rx_frame('{8'hD0, 8'h0D, 8'h04}, 32'h10);
    rx_frame('{8'hD0, 8'h0D, 8'h05}, 32'h20);
    rx_frame('{8'hD0, 8'h0E}, 32'h10);
    rx_frame('{8'hD0, 8'h0F, 8'h01}, 32'h20);
    rx_frame('{8'hD0, 8'h06}, 32'h20);
    $display("test rx condition done");
  endtask : t_rx_sig
  task automatic t_size();
    logic [31:0] cfg[8] = '{32'h0E, 32'h0F, 32'h00020009, 32'h0002000A, 32'h00010018, 32'h0005002C,
      32'h0408000B, 32'h0F0A0001};
    logic [31:0] st[8] = '{32'h00E, 32'h50E, 32'h009, 32'h509, 32'h517, 32'h02C, 32'h30A, 32'h300};
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h24, cfg[i]);
      rd(8'h28, st[i], "size status");
    end
    $display("test size done");
  endtask : t_size
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_tx_teach();
    t_tx_sig();
    t_rx_teach();
    t_rx_sig();
    t_size();
    give_verdict();
  end
endmodule : teach_in_signal_telegram_codec_tb
`default_nettype wire
